// >>> clk_route_pkg.sv
// Notes on behaviour
// R1: at power-up the loop is off and the external input feeds distribution via pre-divider.
// R2: reset restores loop power, divider ratio, bypass and source select defaults.
// R3: with pre-divider in path the division is never below 2.
// R4: software keeps the pre-divider in path when the source exceeds channel input limit.
// R5: external source through pre-divider path stays within the maximum input frequency.
// R6: loop on with external input selected feeds that input into the feedback prescaler.
// R7: internal oscillator stays powered down while the external input is selected.
// R8: staged values only take effect when the update register is written with 0x01; the code commits on any byte-0 write with bit 0 set.
// R9: loop power code 01 is asynchronous power-down, code 00 is normal operation.
// R10: software sets loop power to normal when using the loop with an external oscillator.
// R11: three-bit ratio field selects divide 2 to 6, default code 010 gives 4.
// R12: bypass bit 0 feeds the pre-divider output to distribution.
// R13: source select 0 picks the external input, 1 picks the internal oscillator.
// R14: detector polarity bit 0 is positive, 1 is negative.
// R15: with the internal oscillator software keeps the pre-divider in path.
// R16: calibration bit set to 1 and committed starts oscillator calibration.
// R17: software clears and commits the calibration bit before each later calibration.
// R18: software programs reference, dividers, polarity and pump current before enabling loop.
// R19: bypass bit 1 routes the selected source directly to distribution.
// R20: commit applies all staged routing and divider values in one clock cycle.
package clk_route_pkg;
    localparam int unsigned ADDR_W = 12;
    // register indices; byte address is four times the index
    localparam logic [9:0] IDX_PLL_CONTROL = 10'h010;
    localparam logic [9:0] IDX_OSC_CAL = 10'h018;
    localparam logic [9:0] IDX_PRESCALE = 10'h1e0;
    localparam logic [9:0] IDX_ROUTING = 10'h1e1;
    localparam logic [9:0] IDX_UPDATE = 10'h232;
    localparam logic [9:0] IDX_STATUS = 10'h233;
    localparam logic [7:0] RST_PLL_CONTROL = 8'h01;
    localparam logic [7:0] RST_OSC_CAL = 8'h00;
    localparam logic [7:0] RST_PRESCALE = 8'h02;
    localparam logic [7:0] RST_ROUTING = 8'h00;
    localparam int unsigned PWR_LSB = 0;
    localparam int unsigned POL_BIT = 7;
    localparam int unsigned CAL_BIT = 0;
    localparam int unsigned BYPASS_BIT = 0;
    localparam int unsigned SRCSEL_BIT = 1;
    localparam int unsigned COMMIT_BIT = 0;
    localparam logic [1:0] PWR_NORMAL = 2'h0;
    localparam logic [1:0] PWR_ASYNC_PD = 2'h1;
    localparam logic [2:0] RATIO_MAX_CODE = 3'h4;
    localparam logic [2:0] RATIO_OFFSET = 3'h2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [2:0] {
        WR_IDLE = 3'b001,
        WR_ACCEPT = 3'b010,
        WR_RESP = 3'b100
    } wr_state_t;
    typedef enum logic [2:0] {
        RD_IDLE = 3'b001,
        RD_ACCEPT = 3'b010,
        RD_RESP = 3'b100
    } rd_state_t;
endpackage : clk_route_pkg

// >>> pin_sync.sv
`timescale 1ns/100ps
`default_nettype none
module pin_sync (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic pin_in,
    output logic pin_sync_out
);
    typedef struct packed {
        logic meta;
        logic stable;
    } sync_st_t;
    sync_st_t st_r;
    sync_st_t st_nxt;
    always_comb begin
        st_nxt.meta = pin_in;
        st_nxt.stable = st_r.meta;
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
    assign pin_sync_out = st_r.stable;
endmodule : pin_sync
`default_nettype wire

// >>> prescale_divider.sv
`timescale 1ns/100ps
`default_nettype none
module prescale_divider
    import clk_route_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic src_edge,
    input wire logic [2:0] ratio_code,
    output logic div_tick
);
    typedef struct packed {
        logic [2:0] cnt;
        logic tick;
    } div_st_t;
    div_st_t st_r;
    div_st_t st_nxt;
    logic [2:0] last_cnt;
    always_comb begin
        // count runs 0 to ratio-1; spare codes clamp to the slowest ratio, never to a ratio of 1
        last_cnt = (ratio_code > RATIO_MAX_CODE) ? RATIO_MAX_CODE + RATIO_OFFSET - 3'h1 // R3 R11
                                                 : ratio_code + RATIO_OFFSET - 3'h1;
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        if (src_edge) begin
            // >= so a ratio lowered on commit cannot strand the count
            if (st_r.cnt >= last_cnt) begin
                st_nxt.cnt = 3'h0;
                st_nxt.tick = 1'b1;
            end else begin
                st_nxt.cnt = st_r.cnt + 3'h1;
            end
        end
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
    assign div_tick = st_r.tick;
endmodule : prescale_divider
`default_nettype wire

// >>> clock_source_routing_config.sv
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
module clock_source_routing_config (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [clk_route_pkg::ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [clk_route_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic ext_clk_in,
    input wire logic osc_clk_in,
    output logic dist_tick,
    output logic pll_power_down,
    output logic prescaler_from_ext,
    output logic osc_power_en,
    output logic pfd_negative,
    output logic [2:0] charge_pump_output_mode,
    output logic osc_cal_start
);
    import clk_route_pkg::*;

    typedef struct packed {
        wr_state_t wst;
        rd_state_t rst;
        logic [1:0] bresp;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [7:0] pll_stg;
        logic [7:0] cal_stg;
        logic [7:0] pre_stg;
        logic [7:0] rte_stg;
        logic [7:0] pll_act;
        logic [7:0] cal_act;
        logic [7:0] pre_act;
        logic [7:0] rte_act;
        logic ext_prev;
        logic osc_prev;
        logic dist_tick;
        logic pll_pd;
        logic pre_ext;
        logic osc_pwr;
        logic pfd_neg;
        logic [2:0] cp_mode;
        logic cal_start;
    } st_t;

    st_t st_r;
    st_t st_nxt;
    logic ext_sync;
    logic osc_sync;
    logic div_tick;
    logic sel_edge;
    logic wr_hs;
    logic rd_hs;
    logic commit;
    logic [9:0] widx;
    logic [9:0] ridx;

    pin_sync u_ext_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .pin_in(ext_clk_in),
        .pin_sync_out(ext_sync)
    );

    pin_sync u_osc_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .pin_in(osc_clk_in),
        .pin_sync_out(osc_sync)
    );

    // oscillator edges only count while it is powered and selected
    assign sel_edge = st_r.rte_act[SRCSEL_BIT] ? (osc_sync & ~st_r.osc_prev & st_r.osc_pwr) // R13
                                               : (ext_sync & ~st_r.ext_prev);

    prescale_divider u_prescale (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .src_edge(sel_edge),
        .ratio_code(st_r.pre_act[2:0]),
        .div_tick(div_tick)
    );

    assign widx = awaddr[11:2];
    assign ridx = araddr[11:2];
    assign wr_hs = st_r.wst[1] & awvalid & wvalid;
    assign rd_hs = st_r.rst[1] & arvalid;
    assign commit = wr_hs & wstrb[0] & (widx == IDX_UPDATE) & wdata[COMMIT_BIT]; // R8

    always_comb begin
        st_nxt = st_r;
        st_nxt.ext_prev = ext_sync;
        st_nxt.osc_prev = osc_sync;
        st_nxt.cal_start = 1'b0;

        // write channel: address and data are taken together
        case (st_r.wst)
            WR_IDLE: begin
                if (awvalid && wvalid) begin
                    st_nxt.wst = WR_ACCEPT;
                end
            end
            WR_ACCEPT: begin
                if (wr_hs) begin
                    st_nxt.wst = WR_RESP;
                    st_nxt.bresp = RESP_OKAY;
                    case (widx)
                        IDX_PLL_CONTROL: begin
                            if (wstrb[0]) begin
                                st_nxt.pll_stg = wdata[7:0];
                            end
                        end
                        IDX_OSC_CAL: begin
                            if (wstrb[0]) begin
                                st_nxt.cal_stg = wdata[7:0];
                            end
                        end
                        IDX_PRESCALE: begin
                            if (wstrb[0]) begin
                                st_nxt.pre_stg = wdata[7:0];
                            end
                        end
                        IDX_ROUTING: begin
                            if (wstrb[0]) begin
                                st_nxt.rte_stg = wdata[7:0];
                            end
                        end
                        IDX_UPDATE: begin
                        end
                        default: begin
                            st_nxt.bresp = RESP_SLVERR;
                        end
                    endcase
                end
            end
            WR_RESP: begin
                if (bready) begin
                    st_nxt.wst = WR_IDLE;
                end
            end
            default: begin
                st_nxt.wst = WR_IDLE;
            end
        endcase

        // all staged values move as one word so no mix of old and new escapes
        if (commit) begin
            st_nxt.pll_act = st_r.pll_stg; // R8 R20
            st_nxt.cal_act = st_r.cal_stg;
            st_nxt.pre_act = st_r.pre_stg;
            st_nxt.rte_act = st_r.rte_stg;
            // only a 0 to 1 change of the active bit starts a new calibration
            st_nxt.cal_start = st_r.cal_stg[CAL_BIT] & ~st_r.cal_act[CAL_BIT]; // R16
        end

        // read channel
        case (st_r.rst)
            RD_IDLE: begin
                if (arvalid) begin
                    st_nxt.rst = RD_ACCEPT;
                end
            end
            RD_ACCEPT: begin
                if (rd_hs) begin
                    st_nxt.rst = RD_RESP;
                    st_nxt.rresp = RESP_OKAY;
                    st_nxt.rdata = 32'h0;
                    case (ridx)
                        IDX_PLL_CONTROL: st_nxt.rdata[7:0] = st_r.pll_stg;
                        IDX_OSC_CAL: st_nxt.rdata[7:0] = st_r.cal_stg;
                        IDX_PRESCALE: st_nxt.rdata[7:0] = st_r.pre_stg;
                        IDX_ROUTING: st_nxt.rdata[7:0] = st_r.rte_stg;
                        IDX_UPDATE: st_nxt.rdata[7:0] = 8'h00;
                        IDX_STATUS: st_nxt.rdata[7:0] = {st_r.pll_pd, st_r.osc_pwr, st_r.rte_act[1:0],
                                                         st_r.pre_act[3:0]};
                        default: st_nxt.rresp = RESP_SLVERR;
                    endcase
                end
            end
            RD_RESP: begin
                if (rready) begin
                    st_nxt.rst = RD_IDLE;
                end
            end
            default: begin
                st_nxt.rst = RD_IDLE;
            end
        endcase

        // decoded controls except dist_tick follow the active copy in the same cycle
        st_nxt.pll_pd = (st_nxt.pll_act[1:0] != PWR_NORMAL); // R9
        st_nxt.pre_ext = (st_nxt.pll_act[1:0] == PWR_NORMAL) & ~st_nxt.rte_act[SRCSEL_BIT]; // R6
        st_nxt.osc_pwr = st_nxt.rte_act[SRCSEL_BIT]; // R7
        st_nxt.pfd_neg = st_nxt.pll_act[POL_BIT]; // R14
        st_nxt.cp_mode = st_nxt.pll_act[6:4];
        st_nxt.dist_tick = st_r.rte_act[BYPASS_BIT] ? sel_edge : div_tick; // R12 R19
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
            st_r.wst <= WR_IDLE;
            st_r.rst <= RD_IDLE;
            st_r.pll_stg <= RST_PLL_CONTROL; // R1 R2
            st_r.cal_stg <= RST_OSC_CAL;
            st_r.pre_stg <= RST_PRESCALE; // R11
            st_r.rte_stg <= RST_ROUTING;
            st_r.pll_act <= RST_PLL_CONTROL;
            st_r.cal_act <= RST_OSC_CAL;
            st_r.pre_act <= RST_PRESCALE;
            st_r.rte_act <= RST_ROUTING;
            st_r.pll_pd <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign awready = st_r.wst[1];
    assign wready = st_r.wst[1];
    assign bvalid = st_r.wst[2];
    assign bresp = st_r.bresp;
    assign arready = st_r.rst[1];
    assign rvalid = st_r.rst[2];
    assign rdata = st_r.rdata;
    assign rresp = st_r.rresp;
    assign dist_tick = st_r.dist_tick;
    assign pll_power_down = st_r.pll_pd;
    assign prescaler_from_ext = st_r.pre_ext;
    assign osc_power_en = st_r.osc_pwr;
    assign pfd_negative = st_r.pfd_neg;
    assign charge_pump_output_mode = st_r.cp_mode;
    assign osc_cal_start = st_r.cal_start;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_reset_defaults: assert property ($rose(rst_n) |-> pll_power_down && !osc_power_en // R1 R2
        && st_r.pre_act[2:0] == RST_PRESCALE[2:0] && !st_r.rte_act[BYPASS_BIT])
        else $error("defaults not in force after reset");
    a_stage_hold: assert property (!commit |=> $stable(st_r.pll_act) && $stable(st_r.pre_act) // R8
        && $stable(st_r.rte_act) && $stable(st_r.cal_act))
        else $error("active settings changed without commit");
    a_commit_whole: assert property (commit |=> st_r.pll_act == $past(st_r.pll_stg) // R20
        && st_r.pre_act == $past(st_r.pre_stg) && st_r.rte_act == $past(st_r.rte_stg))
        else $error("commit did not apply all staged values");
    a_power_code: assert property (commit |=> pll_power_down == ($past(st_r.pll_stg[1:0]) != PWR_NORMAL)) // R9
        else $error("loop power output wrong after commit");
    a_osc_off: assert property (!st_r.rte_act[SRCSEL_BIT] |-> !osc_power_en) // R7
        else $error("oscillator powered while external input selected");
    a_feed_ext: assert property (commit && st_r.pll_stg[1:0] == PWR_NORMAL // R6
        && !st_r.rte_stg[SRCSEL_BIT] |=> prescaler_from_ext)
        else $error("external input not fed to prescaler");
    a_pfd_polarity: assert property (commit |=> pfd_negative == $past(st_r.pll_stg[7])) // R14
        else $error("detector polarity not applied");
    a_cal_cause: assert property (osc_cal_start |-> $past(commit) && $past(st_r.cal_stg[0])) // R16
        else $error("calibration started without committed bit");
    a_bypass_route: assert property (st_r.rte_act[BYPASS_BIT] && sel_edge |=> dist_tick) // R19
        else $error("bypassed source edge not passed to distribution");
    a_min_divide: assert property (dist_tick && !st_r.rte_act[BYPASS_BIT] // R3 R12
        && $stable(st_r.rte_act) |=> !dist_tick)
        else $error("pre-divider produced a ratio below 2");

    a_osc_follow: assert property (commit |=> // R13
        osc_power_en == $past(st_r.rte_stg[SRCSEL_BIT]))
        else $error("oscillator power does not follow committed source");
    a_pump_mode: assert property (commit |=> // R20
        charge_pump_output_mode == $past(st_r.pll_stg[6:4]))
        else $error("pump mode not applied with the commit");
    a_cal_start: assert property (commit && st_r.cal_stg[CAL_BIT] // R16
        && !st_r.cal_act[CAL_BIT] |=> osc_cal_start)
        else $error("calibration not started on committed bit");
    // one cycle only, so a held cal bit cannot retrigger the oscillator
    a_cal_pulse: assert property (osc_cal_start // R16
        |=> !osc_cal_start)
        else $error("calibration start held longer than one cycle");
    a_ext_feed_on: assert property (prescaler_from_ext // R6 R7
        |-> !pll_power_down && !osc_power_en)
        else $error("prescaler fed while loop off or oscillator on");

    c_commit: cover property (commit ##1 osc_power_en);
    c_calibrate: cover property (osc_cal_start);
    c_divided_tick: cover property (dist_tick && !st_r.rte_act[BYPASS_BIT]);
    c_bypass_tick: cover property (dist_tick && st_r.rte_act[BYPASS_BIT]);
    c_loop_on: cover property (prescaler_from_ext && pfd_negative);
endmodule : clock_source_routing_config
`default_nettype wire

// >>> clk_source_model.sv
`timescale 1ns/100ps
`default_nettype none
module clk_source_model #(
    parameter int EXT_HALF = 52,
    parameter int OSC_HALF = 72
) (
    input wire logic ext_run,
    input wire logic osc_run,
    output logic ext_clk_in,
    output logic osc_clk_in
);
    // both sources stay well below clk_sys/2 so no edge is lost in the sync flops
    // a stopped source rests low, like an oscillator that is gated off
    // even half periods keep pin edges off the rising edges of clk_sys
    initial begin
        ext_clk_in = 1'b0;
        forever begin
            #EXT_HALF;
            ext_clk_in = ext_run ? ~ext_clk_in : 1'b0;
        end
    end

    initial begin
        osc_clk_in = 1'b0;
        forever begin
            #OSC_HALF;
            osc_clk_in = osc_run ? ~osc_clk_in : 1'b0;
        end
    end
endmodule : clk_source_model
`default_nettype wire

// >>> clock_source_routing_config_tb.sv
`timescale 1ns/100ps
`default_nettype none
module clock_source_routing_config_tb;
    import clk_route_pkg::*;
    logic clk_sys, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, ext_clk_in, osc_clk_in, ext_run, osc_run;
    logic dist_tick, pll_power_down, prescaler_from_ext, osc_power_en, pfd_negative, osc_cal_start;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [2:0] charge_pump_output_mode;
    int bad_count, num_checks, tick_count, edge_count, cal_count;

    clock_source_routing_config dut (.clk_sys(clk_sys), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .ext_clk_in(ext_clk_in),
        .osc_clk_in(osc_clk_in), .dist_tick(dist_tick), .pll_power_down(pll_power_down),
        .prescaler_from_ext(prescaler_from_ext), .osc_power_en(osc_power_en), .pfd_negative(pfd_negative),
        .charge_pump_output_mode(charge_pump_output_mode), .osc_cal_start(osc_cal_start));

    clk_source_model src (.ext_run(ext_run), .osc_run(osc_run), .ext_clk_in(ext_clk_in),
        .osc_clk_in(osc_clk_in));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        if (dist_tick === 1'b1) tick_count++;
        if (osc_cal_start === 1'b1) cal_count++;
    end

    always @(posedge ext_clk_in or posedge osc_clk_in) begin
        edge_count++;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_sim

    // bready and rready stay high throughout, so a response is taken as soon as it shows
    task automatic wr(input logic [9:0] idx, input logic [7:0] val, input logic [3:0] strb = 4'h1,
            input logic [1:0] exp_resp = RESP_OKAY);
        awaddr <= {idx, 2'h0};
        wdata <= {24'h0, val};
        wstrb <= strb;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        check(bresp, exp_resp);
    endtask : wr

    task automatic rd_reg(input logic [9:0] idx, output logic [31:0] d, input logic [1:0] exp_resp = RESP_OKAY);
        araddr <= {idx, 2'h0};
        arvalid <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        check(rresp, exp_resp);
    endtask : rd_reg

    task automatic commit();
        wr(IDX_UPDATE, 8'h01);
    endtask : commit

    // align to a divider boundary first, then count ticks over 60 source edges
    task automatic measure(input logic on_ext, input logic on_osc, input int exp);
        ext_run <= on_ext;
        osc_run <= on_osc;
        if (exp != 0) begin
            @(posedge dist_tick);
            @(posedge clk_sys);
        end
        #1;
        tick_count = 0;
        edge_count = 0;
        wait (edge_count == 60);
        ext_run <= 1'b0;
        osc_run <= 1'b0;
        repeat (20) @(posedge clk_sys);
        check(tick_count, exp);
    endtask : measure

    task automatic check_defaults();
        check(pll_power_down, 1'b1);
        check(osc_power_en, 1'b0);
        check({prescaler_from_ext, pfd_negative, charge_pump_output_mode, osc_cal_start}, 6'h00);
        rd_reg(IDX_PLL_CONTROL, rd);
        check(rd, 32'h01);
        rd_reg(IDX_PRESCALE, rd);
        check(rd, 32'h02);
        rd_reg(IDX_ROUTING, rd);
        check(rd, 32'h00);
        rd_reg(IDX_OSC_CAL, rd);
        check(rd, 32'h00);
        rd_reg(IDX_STATUS, rd);
        check(rd, 32'h82);
    endtask : check_defaults

    initial begin
        #400000;
        bad_count++;
        end_sim();
    end

    initial begin
        {rst_n, awvalid, wvalid, arvalid, ext_run, osc_run} = '0;
        {bready, rready} = 2'b11;
        awaddr = '0;
        araddr = '0;
        wdata = '0;
        wstrb = '0;
        {bad_count, num_checks, tick_count, edge_count, cal_count} = '0;
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        check_defaults();
        measure(1'b1, 1'b0, 15);
        wr(IDX_PRESCALE, 8'h00);
        wr(IDX_UPDATE, 8'h00);
        measure(1'b1, 1'b0, 15);
        for (int c = 0; c < 5; c++) begin
            wr(IDX_PRESCALE, 8'(c));
            commit();
            measure(1'b1, 1'b0, 60 / (c + 2));
        end
        // spare ratio code must clamp to divide-by-6, never fall to 1
        wr(IDX_PRESCALE, 8'h07);
        commit();
        measure(1'b1, 1'b0, 10);
        wr(IDX_PRESCALE, 8'h04);
        wr(IDX_ROUTING, 8'h01);
        commit();
        measure(1'b1, 1'b0, 60);
        wr(IDX_ROUTING, 8'h02);
        commit();
        check(osc_power_en, 1'b1);
        measure(1'b1, 1'b0, 0);
        measure(1'b0, 1'b1, 10);
        // loop on, negative polarity and a pump mode, back on the external input in one commit
        wr(IDX_PLL_CONTROL, 8'hb0);
        wr(IDX_ROUTING, 8'h00);
        commit();
        check(pll_power_down, 1'b0);
        check(prescaler_from_ext, 1'b1);
        check(osc_power_en, 1'b0);
        check({pfd_negative, charge_pump_output_mode}, 4'hb);
        rd_reg(IDX_STATUS, rd);
        check(rd, 32'h04);
        wr(IDX_PLL_CONTROL, 8'h01);
        commit();
        check({pll_power_down, prescaler_from_ext}, 2'b10);
        wr(IDX_PLL_CONTROL, 8'h02);
        commit();
        check({pll_power_down, prescaler_from_ext}, 2'b10);
        wr(IDX_OSC_CAL, 8'h01);
        commit();
        commit();
        check(cal_count, 1);
        wr(IDX_OSC_CAL, 8'h00);
        commit();
        wr(IDX_OSC_CAL, 8'h01);
        commit();
        // the last commit's pulse is counted at this edge, so look one edge later
        @(posedge clk_sys);
        check(cal_count, 2);
        wr(10'h100, 8'h55, 4'h1, RESP_SLVERR);
        rd_reg(10'h100, rd, RESP_SLVERR);
        check(rd, 32'h0);
        wr(IDX_PRESCALE, 8'h03, 4'h0);
        rd_reg(IDX_PRESCALE, rd);
        check(rd, 32'h04);
        rd_reg(IDX_UPDATE, rd);
        check(rd, 32'h0);
        wr(IDX_ROUTING, 8'h03);
        commit();
        rst_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        check_defaults();
        end_sim();
    end
endmodule : clock_source_routing_config_tb
`default_nettype wire
